// File: src/dlk_pkg.sv
// Package of constants for the delay-locked clock deskew block
package dlk_pkg;
	localparam int TAP_W = 6;
	localparam logic [5:0] TAP_MIN = 6'h00;
	localparam logic [5:0] TAP_MAX = 6'h3f;
	localparam int PHASE_W = 4;
	localparam logic [3:0] PHASE_STEPS = 4'h8;
	localparam logic [3:0] PH_QUARTER = 4'h2;
	localparam logic [3:0] PH_HALF = 4'h4;
	localparam logic [3:0] PH_3QUARTER = 4'h6;
	localparam int LOCK_RUN = 4;
	localparam logic [2:0] LOCK_RUN_CNT = 3'h4;
	localparam int RST_DROP_CYCLES = 4;
	localparam int MAX_DIV = 16;
	localparam int GLOBAL_NETS = 2;
	typedef enum logic [4:0] {
		DIV_1P5 = 5'h03,
		DIV_2 = 5'h04,
		DIV_2P5 = 5'h05,
		DIV_3 = 5'h06,
		DIV_4 = 5'h08,
		DIV_5 = 5'h0a,
		DIV_8 = 5'h10,
		DIV_16 = 5'h1f
	} dlk_div_type;
	typedef enum logic [2:0] {
		ST_SEARCH = 3'b001,
		ST_SETTLE = 3'b010,
		ST_LOCKED = 3'b100
	} dlk_state_type;
endpackage

// File: src/dlk_divider.sv
// Half-cycle divider for the divided clock output
`timescale 1ns/100ps
module dlk_divider
	import dlk_pkg::*;
(
	// Clock and control
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic run,
	// Divide factor in half source periods, stored as 2N
	input wire logic [4:0] half_periods,
	// Output
	output logic div_q
);
	logic [4:0] cnt_q, cnt_d;
	logic out_d;
	logic [4:0] limit;

	// Factor 16 is coded 5'h1f to fit five bits; count wraps at 15 and toggles, so the period is 32 halves
	always_comb begin
		limit = (half_periods == 5'h1f) ? 5'h0f : 5'(half_periods - 5'h01);
		cnt_d = cnt_q;
		out_d = div_q;
		if (run) begin
			if (half_periods == 5'h1f) begin
				if (cnt_q == limit) begin
					cnt_d = 5'h00;
					out_d = ~div_q;
				end else begin
					cnt_d = 5'(cnt_q + 5'h01);
				end
			end else if (cnt_q == limit) begin
				cnt_d = 5'h00;
				out_d = 1'b1;
			end else begin
				cnt_d = 5'(cnt_q + 5'h01);
				// High for the first half of the period (floor for odd halves)
				if (5'(cnt_q + 5'h01) >= 5'(half_periods >> 1))
					out_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_q <= 5'h00;
			div_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			div_q <= out_d;
		end
	end
endmodule

// File: src/dlk_deskew.sv
// Delay-locked deskew loop: tap controller, lock, phase, double and divide outputs
`timescale 1ns/100ps
// Model at the clock rate: the source clock is observed as a sampled pin
// and its period is resolved into PHASE_STEPS slots per period.
module dlk_deskew
	import dlk_pkg::*;
(
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// Link pins
	input wire logic source_clock_in,
	input wire logic feedback_clock_in,
	input wire logic loop_reset,
	// Configuration
	input wire logic [4:0] divide_factor_setting,
	input wire logic duty_correct_en,
	input wire logic startup_wait_en,
	input wire logic basic_macro_mode,
	// Clock outputs
	output logic zero_phase_out,
	output logic quarter_phase_out,
	output logic half_phase_out,
	output logic three_quarter_phase_out,
	output logic doubled_clock_out,
	output logic divided_clock_out,
	output logic [GLOBAL_NETS-1:0] global_net_out,
	// Status
	output logic locked_out,
	output logic config_done_out,
	output logic [TAP_W-1:0] tap_setting_out
);
	logic [1:0] src_sync_q, fb_sync_q, rst_sync_q;
	logic src_prev_q, fb_prev_q;
	logic [3:0] slot_q, slot_d;
	logic [TAP_W-1:0] tap_q, tap_d;
	logic [2:0] run_q, run_d;
	dlk_state_type state_q, state_d;
	logic lock_d;
	logic src_rise, fb_rise, loop_rst;
	logic [PHASE_STEPS-1:0] tapline_q;
	logic [3:0] ph_out_d;
	logic dbl_d, div_raw, src_dly;
	logic [4:0] div_half;

	// Pins come from outside the domain: two flops each
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			src_sync_q <= 2'b00;
			fb_sync_q <= 2'b00;
			rst_sync_q <= 2'b00;
			src_prev_q <= 1'b0;
			fb_prev_q <= 1'b0;
		end else begin
			src_sync_q <= {src_sync_q[0], source_clock_in};
			fb_sync_q <= {fb_sync_q[0], feedback_clock_in};
			// Basic macro hides the loop reset
			rst_sync_q <= {rst_sync_q[0], loop_reset & ~basic_macro_mode};
			src_prev_q <= src_sync_q[1];
			fb_prev_q <= fb_sync_q[1];
		end
	end

	assign src_rise = src_sync_q[1] & ~src_prev_q;
	assign fb_rise = fb_sync_q[1] & ~fb_prev_q;
	assign loop_rst = sys_rst | rst_sync_q[1];

	// Discrete tap line: each stage is one slot of delay
	always_ff @(posedge clock) begin
		if (loop_rst)
			tapline_q <= '0;
		else
			tapline_q <= {tapline_q[PHASE_STEPS-2:0], src_sync_q[1]};
	end
	assign src_dly = tapline_q[tap_q[2:0]];

	// Tap controller: step one tap per source edge not yet matched
	always_comb begin
		state_d = state_q;
		tap_d = tap_q;
		run_d = run_q;
		lock_d = 1'b0;
		case (state_q)
			ST_SEARCH: begin
				if (src_rise && fb_rise) begin
					state_d = ST_SETTLE;
					run_d = 3'h1;
				end else if (src_rise) begin
					tap_d = (tap_q == TAP_MAX) ? TAP_MIN : 6'(tap_q + 6'h01);
				end
			end
			ST_SETTLE: begin
				if (src_rise && !fb_rise) begin
					state_d = ST_SEARCH;
					run_d = 3'h0;
				end else if (src_rise) begin
					run_d = 3'(run_q + 3'h1);
					if (run_q + 3'h1 == LOCK_RUN_CNT)
						state_d = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				lock_d = 1'b1;
				if (src_rise && !fb_rise) begin
					state_d = ST_SEARCH;
					run_d = 3'h0;
				end
			end
			default: begin
				state_d = ST_SEARCH;
			end
		endcase
		if (state_d == ST_LOCKED)
			lock_d = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (loop_rst) begin
			state_q <= ST_SEARCH;
			tap_q <= TAP_MIN;
			run_q <= 3'h0;
			locked_out <= 1'b0;
		end else begin
			state_q <= state_d;
			tap_q <= tap_d;
			run_q <= run_d;
			locked_out <= lock_d & ~basic_macro_mode;
		end
	end

	// Slot counter across one source period for phase synthesis
	always_comb begin
		// Slot zero is the source rise, so 0..7 split the period into equal quarters
		slot_d = src_rise ? 4'h0 : ((slot_q == 4'hf) ? slot_q : 4'(slot_q + 4'h1));
	end

	always_ff @(posedge clock) begin
		if (loop_rst)
			slot_q <= 4'h0;
		else
			slot_q <= slot_d;
	end

	// Phase outputs: 50-50 from the slot count, or raw taps when uncorrected
	always_comb begin
		if (duty_correct_en) begin
			ph_out_d[0] = (slot_d < PH_HALF);
			ph_out_d[1] = (slot_d >= PH_QUARTER) && (slot_d < PH_3QUARTER);
			ph_out_d[2] = (slot_d >= PH_HALF);
			ph_out_d[3] = (slot_d < PH_QUARTER) || (slot_d >= PH_3QUARTER);
		end else begin
			ph_out_d[0] = src_dly;
			ph_out_d[1] = tapline_q[PH_QUARTER[2:0]];
			ph_out_d[2] = ~src_dly;
			ph_out_d[3] = ~tapline_q[PH_QUARTER[2:0]];
		end
		// Before lock: 1x at 25/75 so the loop locks on the right edge
		if (state_q != ST_LOCKED)
			dbl_d = (slot_d < PH_QUARTER);
		else
			dbl_d = (slot_d < PH_QUARTER) ||
				((slot_d >= PH_HALF) && (slot_d < PH_3QUARTER));
	end

	assign div_half = (divide_factor_setting == 5'h00) ? DIV_2 : divide_factor_setting;

	dlk_divider u_div (
		.clock(clock),
		.sys_rst(loop_rst),
		.run((slot_d == 4'h1) || (slot_d == PH_HALF + 4'h1)),
		.half_periods(div_half),
		.div_q(div_raw)
	);

	always_ff @(posedge clock) begin
		if (loop_rst) begin
			zero_phase_out <= 1'b0;
			quarter_phase_out <= 1'b0;
			half_phase_out <= 1'b0;
			three_quarter_phase_out <= 1'b0;
			doubled_clock_out <= 1'b0;
			divided_clock_out <= 1'b0;
			global_net_out <= '0;
			config_done_out <= 1'b0;
			tap_setting_out <= TAP_MIN;
		end else begin
			zero_phase_out <= ph_out_d[0];
			quarter_phase_out <= ph_out_d[1] & ~basic_macro_mode;
			half_phase_out <= ph_out_d[2] & ~basic_macro_mode;
			three_quarter_phase_out <= ph_out_d[3] & ~basic_macro_mode;
			doubled_clock_out <= dbl_d & ~basic_macro_mode;
			divided_clock_out <= div_raw & ~basic_macro_mode;
			// Two global nets at most: zero phase and doubled
			global_net_out <= {dbl_d & ~basic_macro_mode, ph_out_d[0]};
			config_done_out <= ~startup_wait_en | lock_d;
			tap_setting_out <= tap_d;
		end
	end

	// Lock drops within four cycles of the loop reset pin
	property p_lock_drop;
		@(posedge clock) disable iff (sys_rst)
		rst_sync_q[1] |-> ##1 !locked_out;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock held after reset");

	property p_tap_min;
		@(posedge clock) disable iff (sys_rst)
		rst_sync_q[1] |=> tap_setting_out == TAP_MIN;
	endproperty
	a_tap_min: assert property (p_tap_min) else $error("taps not at minimum");

	sequence s_aligned_run;
		state_q == ST_SETTLE && run_q == 3'h3 && src_rise && fb_rise;
	endsequence
	property p_lock_on_align;
		@(posedge clock) disable iff (loop_rst)
		s_aligned_run |=> locked_out;
	endproperty
	a_lock_on_align: assert property (p_lock_on_align) else $error("no lock on align");

	property p_step;
		@(posedge clock) disable iff (loop_rst)
		(state_q == ST_SEARCH && src_rise && !fb_rise && tap_q != TAP_MAX) |=>
			tap_q == $past(tap_q) + 6'h01;
	endproperty
	a_step: assert property (p_step) else $error("tap did not step");

	property p_done;
		@(posedge clock) disable iff (loop_rst)
		(startup_wait_en && !locked_out && !lock_d) |=> !config_done_out;
	endproperty
	a_done: assert property (p_done) else $error("done before lock");

	property p_dbl_prelock;
		@(posedge clock) disable iff (loop_rst)
		(state_q == ST_SEARCH && slot_d >= PH_QUARTER) |=> !doubled_clock_out;
	endproperty
	a_dbl_prelock: assert property (p_dbl_prelock) else $error("doubled not 25/75");

	property p_half_phase;
		@(posedge clock) disable iff (loop_rst)
		(duty_correct_en && !basic_macro_mode) |=> half_phase_out == !zero_phase_out;
	endproperty
	a_half_phase: assert property (p_half_phase) else $error("half phase wrong");

	property p_basic_hide;
		@(posedge clock) disable iff (loop_rst)
		basic_macro_mode |=> !locked_out && !divided_clock_out && !doubled_clock_out;
	endproperty
	a_basic_hide: assert property (p_basic_hide) else $error("basic exposes pins");
endmodule

// File: tb/dlk_clock_source.sv
// Model of the external clock source and the on-chip distribution network
`timescale 1ns/100ps
module dlk_clock_source (
	// System
	input wire logic clock,
	// Waveform in system clocks and network delay of the feedback sample
	input wire logic [3:0] period,
	input wire logic [3:0] high_len,
	input wire logic [3:0] skew,
	// Pins
	output logic source_clock_in,
	output logic feedback_clock_in
);
	logic [3:0] cnt_q = 4'h0;
	logic [15:0] hist_q = 16'h0;
	initial source_clock_in = 1'b0;
	// Free-running oscillator seen on a dedicated input pin only
	always @(posedge clock) begin
		cnt_q <= #2 (cnt_q + 4'h1 >= period) ? 4'h0 : cnt_q + 4'h1;
		source_clock_in <= #2 (cnt_q < high_len);
		hist_q <= #2 {hist_q[14:0], cnt_q < high_len};
	end
	// A skew of zero models a network whose delay is already compensated
	assign feedback_clock_in = hist_q[skew];
endmodule

// File: tb/tb_dlk_deskew.sv
// Self-checking bench for the delay-locked clock deskew loop
`timescale 1ns/100ps
module tb_dlk_deskew;
	import dlk_pkg::*;
	localparam int P = 8;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic loop_reset = 1'b0;
	logic [4:0] divide_factor_setting = 5'h00;
	logic duty_correct_en = 1'b1;
	logic startup_wait_en = 1'b1;
	logic basic_macro_mode = 1'b0;
	logic [3:0] high_len = 4'h4;
	logic [3:0] skew = 4'h0;
	logic source_clock_in, feedback_clock_in, locked_out, config_done_out;
	logic zero_phase_out, quarter_phase_out, half_phase_out, three_quarter_phase_out;
	logic doubled_clock_out, divided_clock_out;
	logic [GLOBAL_NETS-1:0] global_net_out;
	logic [TAP_W-1:0] tap_setting_out;
	logic [7:0] mon;
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	initial forever #4 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	assign mon = {global_net_out, divided_clock_out, doubled_clock_out,
		three_quarter_phase_out, half_phase_out, quarter_phase_out, zero_phase_out};
	dlk_clock_source dlk_clock_source_i (.clock(clock), .period(4'h8), .high_len(high_len),
		.skew(skew), .source_clock_in(source_clock_in), .feedback_clock_in(feedback_clock_in));
	dlk_deskew dlk_deskew_i (.clock(clock), .sys_rst(sys_rst), .source_clock_in(source_clock_in),
		.feedback_clock_in(feedback_clock_in), .loop_reset(loop_reset),
		.divide_factor_setting(divide_factor_setting), .duty_correct_en(duty_correct_en),
		.startup_wait_en(startup_wait_en), .basic_macro_mode(basic_macro_mode),
		.zero_phase_out(zero_phase_out), .quarter_phase_out(quarter_phase_out),
		.half_phase_out(half_phase_out), .three_quarter_phase_out(three_quarter_phase_out),
		.doubled_clock_out(doubled_clock_out), .divided_clock_out(divided_clock_out),
		.global_net_out(global_net_out), .locked_out(locked_out),
		.config_done_out(config_done_out), .tap_setting_out(tap_setting_out));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Inputs move and outputs are read 2 ns after the edge, after all updates land
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic rise(input int idx, output int t);
		logic p;
		int n;
		n = 0;
		p = mon[idx];
		tick(1);
		while (!(mon[idx] === 1'b1 && p === 1'b0) && n < 300) begin
			p = mon[idx];
			n++;
			tick(1);
		end
		if (n >= 300) chk(32'h0, 32'h1);
		t = cyc;
	endtask
	task automatic span(input int idx, input int exp);
		int a;
		int b;
		rise(idx, a);
		rise(idx, b);
		chk(b - a, exp);
	endtask
	task automatic hightime(input int idx, input int exp);
		int a;
		int h;
		rise(idx, a);
		h = 0;
		while (mon[idx] === 1'b1 && h < 300) begin
			h++;
			tick(1);
		end
		chk(h, exp);
	endtask
	task automatic wait_lock();
		int n;
		n = 0;
		while (locked_out !== 1'b1 && n < 400) begin
			n++;
			tick(1);
		end
		chk({31'h0, locked_out}, 1);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Whole sequence needs under two thousand cycles; allow ample margin
	initial begin
		#(20000 * P * 1ns);
		miscompares++;
		give_verdict();
	end
	initial begin
		logic [4:0] sets [9] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0a, 5'h10, 5'h1f, 5'h00};
		int halves [9] = '{3, 4, 5, 6, 8, 10, 16, 32, 4};
		logic [TAP_W-1:0] t0;
		int a;
		int n;
		int r;
		r = $urandom(32'h2fb6);
		high_len = 4'(2 + $urandom % 5);
		tick(8);
		chk({24'h0, config_done_out, locked_out, tap_setting_out}, 0);
		sys_rst = 1'b0;
		$display("test reset done");
		// Misaligned feedback: one tap step per source period, no lock yet
		repeat (3) begin
			skew = 4'(1 + $urandom % (P - 1));
			tick(3 * P);
			t0 = tap_setting_out;
			tick(P);
			chk({26'h0, 6'(tap_setting_out - t0)}, 1);
			chk({30'h0, locked_out, config_done_out}, 0);
		end
		// Without the startup wait, configuration completes even before lock
		startup_wait_en = 1'b0;
		tick(2);
		chk({31'h0, config_done_out}, 1);
		startup_wait_en = 1'b1;
		tick(2);
		chk({31'h0, config_done_out}, 0);
		hightime(4, P / 4);
		span(4, P);
		$display("test search done");
		skew = 4'h0;
		wait_lock();
		chk({31'h0, config_done_out}, 1);
		t0 = tap_setting_out;
		tick(2 * P);
		chk({26'h0, tap_setting_out}, {26'h0, t0});
		for (int k = 1; k < 4; k++) begin
			rise(0, a);
			rise(k, n);
			chk(n - a, k * P / 4);
		end
		hightime(0, P / 2);
		duty_correct_en = 1'b0;
		tick(2 * P);
		hightime(0, high_len);
		duty_correct_en = 1'b1;
		span(4, P / 2);
		repeat (2 * P) begin
			tick(1);
			chk(global_net_out, {doubled_clock_out, zero_phase_out});
		end
		$display("test locked outputs done");
		r = $urandom % 9;
		for (int i = 0; i < 9; i++) begin
			divide_factor_setting = sets[(i + r) % 9];
			rise(5, a);
			span(5, P * halves[(i + r) % 9] / 2);
		end
		$display("test divide done");
		loop_reset = 1'b1;
		n = 0;
		while (locked_out === 1'b1 && n < 10) begin
			n++;
			tick(1);
		end
		chk(n <= 4, 1);
		tick(4);
		chk({25'h0, locked_out, tap_setting_out}, {25'h0, 1'b0, TAP_MIN});
		loop_reset = 1'b0;
		wait_lock();
		$display("test loop reset done");
		basic_macro_mode = 1'b1;
		loop_reset = 1'b1;
		tick(8);
		repeat (3 * P) begin
			tick(1);
			chk({locked_out, mon[7], mon[5:1]}, 0);
			chk(mon[6], mon[0]);
		end
		span(0, P);
		$display("test basic macro done");
		give_verdict();
	end
endmodule
